// ---- sgdi_intake.sv ----
// Descriptor intake end: stages lane writes and commits a decoded descriptor.
// Assumes a writer on the same clock driving the intake modport.
// Assumes the transfer type and stream inputs come from logic on sys_clk.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// RULE1 - Port is 128 or 256 bits by format
// RULE2 - Standard: src, dst, length, control offsets
// RULE3 - Extended: tag, strides, high addresses, control
// RULE4 - Each byte lane is written independently
// RULE5 - Final control bit pushes staged descriptor
// RULE6 - Commit is control bit 31 written one
// RULE7 - Writer omits unused address per transfer type
// RULE8 - Unused address field is ignored
// RULE9 - Standard format keeps only low 32 bits
// RULE10 - Length gives bytes to transfer
// RULE11 - Packet S2M stops at length limit
// RULE12 - Sequence number tracked per host
// RULE13 - Burst 1..128 direct, zero selects maximum
// RULE14 - Burst above 128 yields 128
// RULE15 - Stride counted in host words
// RULE16 - Stride one sequential, zero repeats, default
// RULE17 - Separate read and write strides
// RULE18 - Commit is atomic; staging reusable
module sgdi_intake
  import sgdi_pkg::*;
#(
  parameter bit EXTENDED = 1'b1,
  parameter bit BURST_EN = 1'b1,
  parameter bit STRIDE_EN = 1'b1,
  parameter logic [10:0] MAX_BURST = 11'd1024,
  parameter int unsigned DATA_BYTES = 4
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  sgdi_link_if.intake link,
  input wire sgdi_pkg::sgdi_xfer_t xferType,
  input wire logic packetEn,
  input wire logic [31:0] streamBytes,
  input wire logic streamEop,
  output sgdi_pkg::sgdi_desc_t descOut,
  output logic descValid,
  output logic [10:0] readBurstLen,
  output logic [10:0] writeBurstLen,
  output logic [31:0] readStepBytes,
  output logic [31:0] writeStepBytes,
  output logic [15:0] readSeq,
  output logic [15:0] writeSeq,
  output logic streamStop
);
  import sgdi_pkg::*;

  // The control word closes the descriptor, so where it sits depends on the format.
  localparam int ACTIVE_W = EXTENDED ? EXT_WIDTH : STD_WIDTH;
  localparam logic [4:0] CTRL_OFF = EXTENDED ? OFF_EXT_CTRL : OFF_STD_CTRL;

  // Staged lanes, the write as masked to the active width, and the commit strobe.
  logic [PORT_WIDTH-1:0] staged;
  logic [PORT_WIDTH-1:0] maskedData;
  logic [LANES-1:0] maskedLanes;
  logic commitNow;
  sgdi_desc_t decoded;

  // Lanes beyond the configured width never reach the staging store. [RULE1]
  // A standard writer may still drive the upper lanes; they are simply dropped.
  always_comb begin
    maskedData = link.writeData;
    maskedLanes = link.byteEnable;
    if (ACTIVE_W == STD_WIDTH) begin
      maskedLanes[LANES-1:STD_WIDTH/8] = '0;
    end
  end

  // The staging store keeps each lane until a later write to that same lane.
  sgdi_lane_stage uStage (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wrEn(link.write),
    .laneEn(maskedLanes),
    .wrData(maskedData),
    .staged(staged)
  );

  // Intake never stalls; commit takes a single cycle.
  // Nothing downstream can refuse a lane, so back-pressure would only cost cycles.
  assign link.waitRequest = 1'b0;

  // Commit fires when the top control lane carries bit 31 as one. [RULE5] [RULE6]
  assign commitNow = link.write && link.byteEnable[CTRL_OFF + 5'd3]
    && link.writeData[CTRL_OFF*8 + COMMIT_BIT];

  // One 32-bit descriptor word at a byte offset of the port.
  function automatic logic [31:0] pickWord(input logic [PORT_WIDTH-1:0] v,
                                           input logic [4:0] off);
    pickWord = v[off*8 +: 32];
  endfunction

  // The commit write's own lanes merge with staged lanes so it lands whole.
  // Without the merge a descriptor committed in one write would lose its fields.
  function automatic logic [31:0] mergeWord(input logic [4:0] off);
    logic [31:0] w;
    w = pickWord(staged, off);
    for (int b = 0; b < 4; b++) begin
      if (maskedLanes[off + b]) begin
        w[b*8 +: 8] = link.writeData[(off + b)*8 +: 8];
      end
    end
    mergeWord = w;
  endfunction

  // Field decode by format and transfer type.
  always_comb begin
    decoded = '0;
    decoded.srcAddr[31:0] = mergeWord(OFF_SRC_LO); // [RULE2]
    decoded.dstAddr[31:0] = mergeWord(OFF_DST_LO);
    decoded.length = mergeWord(OFF_LENGTH); // [RULE10]
    decoded.control = mergeWord(CTRL_OFF);
    // Strides fall back to one word, the sequential default.
    decoded.readStride = STRIDE_RESET;
    decoded.writeStride = STRIDE_RESET;
    // High address halves, tag, bursts and strides exist only in the extended format.
    if (EXTENDED) begin
      decoded.seqNum = 16'(mergeWord(OFF_TAG_BURST) >> SEQ_LSB); // [RULE3]
      decoded.readBurst = 8'(mergeWord(OFF_TAG_BURST) >> RBURST_LSB);
      decoded.writeBurst = 8'(mergeWord(OFF_TAG_BURST) >> WBURST_LSB);
      decoded.srcAddr[63:32] = mergeWord(OFF_SRC_HI); // [RULE9]
      decoded.dstAddr[63:32] = mergeWord(OFF_DST_HI);
      if (STRIDE_EN) begin
        decoded.readStride = 16'(mergeWord(OFF_STRIDES) >> RSTRIDE_LSB); // [RULE17]
        decoded.writeStride = 16'(mergeWord(OFF_STRIDES) >> WSTRIDE_LSB);
      end
    end
    // Addresses with no memory side are dropped. [RULE8] [RULE7]
    if (xferType == XFER_MM2ST) begin
      decoded.dstAddr = '0;
    end
    if (xferType == XFER_ST2MM) begin
      decoded.srcAddr = '0;
    end
  end

  // Zero, or a host without programmable bursts, gets the configured maximum.
  // Counts above the cap are clipped rather than refused, so no descriptor is lost.
  function automatic logic [10:0] burstLen(input logic [7:0] prog);
    if (!EXTENDED || !BURST_EN || prog == 8'h00) begin
      burstLen = MAX_BURST; // [RULE13]
    end else if (prog > BURST_CAP) begin
      burstLen = 11'(BURST_CAP); // [RULE14]
    end else begin
      burstLen = 11'(prog);
    end
  endfunction

  // Commit captures everything in one edge; staging stays free. [RULE18]
  // Outputs are registered so the dispatcher sees one settled descriptor per push.
  // A new commit may follow at once, since staging is never locked.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      descOut <= '0;
      descValid <= 1'b0;
      readBurstLen <= 11'd0;
      writeBurstLen <= 11'd0;
      readStepBytes <= ZERO_WORD;
      writeStepBytes <= ZERO_WORD;
    end else begin
      // The push flag is a one-cycle pulse.
      descValid <= commitNow;
      if (commitNow) begin
        descOut <= decoded;
        readBurstLen <= burstLen(decoded.readBurst);
        writeBurstLen <= burstLen(decoded.writeBurst);
        readStepBytes <= 32'(decoded.readStride) * 32'(DATA_BYTES); // [RULE15] [RULE16]
        writeStepBytes <= 32'(decoded.writeStride) * 32'(DATA_BYTES);
      end
    end
  end

  // Each host keeps its own sequence tag; a memory-to-memory commit gives both hosts the same tag. [RULE12]
  // A host that a transfer type leaves unused keeps the tag of its last descriptor.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      readSeq <= 16'h0000;
      writeSeq <= 16'h0000;
    end else if (commitNow && EXTENDED) begin
      // Stream-to-memory has no read host to track.
      if (xferType != XFER_ST2MM) begin
        readSeq <= decoded.seqNum;
      end
      if (xferType != XFER_MM2ST) begin
        writeSeq <= decoded.seqNum;
      end
    end
  end

  // Length limit reached; an all-ones length lifts the limit.
  // The limit is checked against the committed length, not the staged one.
  logic lengthHit;
  assign lengthHit = descOut.length != LENGTH_UNLIMITED && streamBytes >= descOut.length;

  // Packet stream-to-memory stops once length is reached before end of packet.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      streamStop <= 1'b0;
    end else if (commitNow) begin
      streamStop <= 1'b0;
    end else begin
      streamStop <= packetEn && xferType == XFER_ST2MM && !streamEop && lengthHit; // [RULE11]
    end
  end
endmodule

// ---- sgdi_pkg.sv ----
// Shared constants and types for the descriptor intake link and its two ends.
// Assumes a single 200 MHz clock domain shared by writer and intake.
package sgdi_pkg;
  localparam int STD_WIDTH = 128;
  localparam int EXT_WIDTH = 256;
  localparam int PORT_WIDTH = EXT_WIDTH;
  localparam int LANES = PORT_WIDTH / 8;
  localparam int WORDS = PORT_WIDTH / 32;
  // Byte offsets of descriptor words.
  localparam logic [4:0] OFF_SRC_LO = 5'h00;
  localparam logic [4:0] OFF_DST_LO = 5'h04;
  localparam logic [4:0] OFF_LENGTH = 5'h08;
  localparam logic [4:0] OFF_STD_CTRL = 5'h0C;
  localparam logic [4:0] OFF_TAG_BURST = 5'h0C;
  localparam logic [4:0] OFF_STRIDES = 5'h10;
  localparam logic [4:0] OFF_SRC_HI = 5'h14;
  localparam logic [4:0] OFF_DST_HI = 5'h18;
  localparam logic [4:0] OFF_EXT_CTRL = 5'h1C;
  // Field positions.
  localparam int COMMIT_BIT = 31;
  localparam int SEQ_LSB = 0;
  localparam int RBURST_LSB = 16;
  localparam int WBURST_LSB = 24;
  localparam int RSTRIDE_LSB = 0;
  localparam int WSTRIDE_LSB = 16;
  localparam logic [7:0] BURST_CAP = 8'h80;
  localparam logic [15:0] STRIDE_RESET = 16'h0001;
  localparam logic [31:0] LENGTH_UNLIMITED = 32'hFFFF_FFFF;
  // APB register map of the writer.
  localparam logic [7:0] REG_DATA0 = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h20;
  localparam logic [7:0] REG_LANES = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_COUNT = 8'h2C;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    XFER_MM2MM = 2'b00,
    XFER_MM2ST = 2'b01,
    XFER_ST2MM = 2'b10
  } sgdi_xfer_t;

  typedef struct packed {
    logic [63:0] srcAddr;
    logic [63:0] dstAddr;
    logic [31:0] length;
    logic [15:0] seqNum;
    logic [7:0] readBurst;
    logic [7:0] writeBurst;
    logic [15:0] readStride;
    logic [15:0] writeStride;
    logic [31:0] control;
  } sgdi_desc_t;
endpackage

// ---- sgdi_link_if.sv ----
// Descriptor agent port joining the writer and the intake.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/1ps
interface sgdi_link_if;
  import sgdi_pkg::*;
  logic write;
  logic [4:0] address;
  logic [PORT_WIDTH-1:0] writeData;
  logic [LANES-1:0] byteEnable;
  logic waitRequest;

  modport writer (output write, output address, output writeData, output byteEnable,
    input waitRequest);
  modport intake (input write, input address, input writeData, input byteEnable,
    output waitRequest);
endinterface

// ---- sgdi_lane_stage.sv ----
// Byte-lane staging memory for one descriptor.
// Assumes writes arrive on the intake clock with per-lane enables.
`timescale 1ns/1ps
module sgdi_lane_stage
  import sgdi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [LANES-1:0] laneEn,
  input wire logic [PORT_WIDTH-1:0] wrData,
  output logic [PORT_WIDTH-1:0] staged
);
  import sgdi_pkg::*;

  // Each lane is its own register so any access size can fill a field.
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          staged[g*8 +: 8] <= 8'h00;
        end else if (wrEn && laneEn[g]) begin
          staged[g*8 +: 8] <= wrData[g*8 +: 8]; // [RULE4]
        end
      end
    end
  endgenerate
endmodule

// ---- sgdi_writer.sv ----
// Writer end: APB slave whose registers drive descriptor writes onto the link.
// Assumes an APB master on sys_clk and the intake on the far modport.
`timescale 1ns/1ps
module sgdi_writer
  import sgdi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sgdi_link_if.writer link
);
  import sgdi_pkg::*;

  logic [31:0] dataWord_reg [WORDS];
  logic [4:0] addr_reg;
  logic [LANES-1:0] lanes_reg;
  logic busy_reg;
  logic [31:0] count_reg;
  logic apbWrite;
  logic apbRead;
  logic mapped;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && penable && !pwrite;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= REG_COUNT;

  // Data words and lane register; writing the lane register launches one link write.
  // Every register write is refused while busy so data cannot change mid-write.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < WORDS; i++) begin
        dataWord_reg[i] <= ZERO_WORD;
      end
      addr_reg <= 5'h00;
      lanes_reg <= '0;
    end else if (apbWrite && !busy_reg) begin
      if (paddr < REG_ADDR) begin
        dataWord_reg[paddr[4:2]] <= pwdata;
      end else if (paddr == REG_ADDR) begin
        addr_reg <= pwdata[4:0];
      end else if (paddr == REG_LANES) begin
        lanes_reg <= pwdata[LANES-1:0];
      end
    end
  end

  // Link drive: one cycle write, held while the intake asks for wait.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      count_reg <= ZERO_WORD;
    end else if (busy_reg) begin
      if (!link.waitRequest) begin
        busy_reg <= 1'b0;
        count_reg <= count_reg + 32'h0000_0001;
      end
    end else if (apbWrite && paddr == REG_LANES) begin
      busy_reg <= 1'b1;
    end
  end

  // Lanes are placed at the word offset; the writer puts the control word last. [RULE5]
  always_comb begin
    link.write = busy_reg;
    link.address = addr_reg;
    link.writeData = '0;
    link.byteEnable = '0;
    for (int i = 0; i < WORDS; i++) begin
      link.writeData[i*32 +: 32] = dataWord_reg[i];
    end
    if (busy_reg) begin
      link.byteEnable = lanes_reg;
    end
  end

  // APB answer in the access cycle; unmapped or busy writes flag an error.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= ZERO_WORD;
      if (paddr < REG_ADDR) begin
        prdata <= dataWord_reg[paddr[4:2]];
      end else if (paddr == REG_ADDR) begin
        prdata <= 32'(addr_reg);
      end else if (paddr == REG_LANES) begin
        prdata <= 32'(lanes_reg);
      end else if (paddr == REG_STATUS) begin
        prdata <= 32'(busy_reg);
      end else if (paddr == REG_COUNT) begin
        prdata <= count_reg;
      end
    end
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && (!mapped || (pwrite && busy_reg));
endmodule

// ---- sgdi_link_sva.sv ----
// Checker for the descriptor link between the writer and the intake.
// Assumes the extended format, so the commit bit is the top bit of lane 31.
`timescale 1ns/1ps
module sgdi_link_sva
  import sgdi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic write,
  input wire logic [4:0] address,
  input wire logic [PORT_WIDTH-1:0] writeData,
  input wire logic [LANES-1:0] byteEnable,
  input wire logic waitRequest,
  input wire logic descValid
);
  // One clock domain, so one clocking and one reset serve every check.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // A commit write enables the control word's top lane and sets its top bit.
  wire logic go = write && byteEnable[LANES-1] && writeData[PORT_WIDTH-1];

  a_commit_pushes: assert property (go |=> descValid)
    else $error("descriptor not pushed after commit write");
  a_push_has_cause: assert property (descValid |-> $past(go))
    else $error("descriptor pushed without commit write");
  a_lane_off_hold: assert property (write && !byteEnable[LANES-1] |=> !descValid)
    else $error("push without the control lane enabled");
  a_bit_clear_hold: assert property (write && byteEnable[LANES-1] && !writeData[PORT_WIDTH-1]
    |=> !descValid)
    else $error("push with the commit bit clear");
  a_push_one_cycle: assert property (descValid |=> !descValid)
    else $error("push flag held longer than one cycle");
  a_write_single: assert property (write |=> !write)
    else $error("link write held longer than one cycle");
  a_never_stalls: assert property (waitRequest == 1'b0)
    else $error("intake stalled the link");
  a_push_then_quiet: assert property (descValid |-> !write)
    else $error("link write overlaps the push cycle");

  c_commit: cover property (go);
  c_partial: cover property (write && !byteEnable[LANES-1]);
  c_push: cover property (descValid ##1 !descValid);
endmodule

// ---- tb_top.sv ----
// Testbench joining writer and intake; APB stimulus, intake outputs checked.
// Assumes the extended format with bursts and strides; a standard intake listens alongside.
`timescale 1ns/1ps
module tb_top;
  import sgdi_pkg::*;
  localparam logic [10:0] MAX_B = 11'd1024;
  localparam int DB = 4;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, perr = 0, got = 0;
  logic packetEn = 1, streamEop = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, streamBytes = 0, prdata, rdv;
  logic pready, pslverr, descValid, streamStop;
  logic [10:0] readBurstLen, writeBurstLen;
  logic [31:0] readStepBytes, writeStepBytes;
  logic [15:0] readSeq, writeSeq, rs = 0, ws = 0;
  sgdi_xfer_t xt = XFER_MM2MM;
  sgdi_desc_t descOut;
  sgdi_desc_t stdDesc;
  logic stdValid, gotStd = 0;
  logic [10:0] stdRBurst;
  logic [31:0] stdRStep;
  logic [31:0] w [8], e [8];
  logic [7:0] bt [5] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'hFF};
  int error_cnt = 0, n_checks = 0, seed = 1029;

  sgdi_link_if link();
  sgdi_writer sgdi_writer_inst(.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  sgdi_intake #(.MAX_BURST(MAX_B), .DATA_BYTES(DB)) sgdi_intake_inst(.sys_clk(sys_clk),
    .nrst(nrst), .link(link), .xferType(xt), .packetEn(packetEn), .streamBytes(streamBytes),
    .streamEop(streamEop), .descOut(descOut), .descValid(descValid),
    .readBurstLen(readBurstLen), .writeBurstLen(writeBurstLen), .readStepBytes(readStepBytes),
    .writeStepBytes(writeStepBytes), .readSeq(readSeq), .writeSeq(writeSeq),
    .streamStop(streamStop));
  sgdi_link_sva sgdi_link_sva_inst(.sys_clk(sys_clk), .nrst(nrst), .write(link.write),
    .address(link.address), .writeData(link.writeData), .byteEnable(link.byteEnable),
    .waitRequest(link.waitRequest), .descValid(descValid));

  // A standard-format intake listens to the same writes on a copy of the link.
  sgdi_link_if stdLink();
  assign stdLink.write = link.write;
  assign stdLink.address = link.address;
  assign stdLink.writeData = link.writeData;
  assign stdLink.byteEnable = link.byteEnable;
  sgdi_intake #(.EXTENDED(1'b0), .MAX_BURST(MAX_B), .DATA_BYTES(DB)) sgdi_intake_std_inst(
    .sys_clk(sys_clk), .nrst(nrst), .link(stdLink), .xferType(xt), .packetEn(packetEn),
    .streamBytes(streamBytes), .streamEop(streamEop), .descOut(stdDesc), .descValid(stdValid),
    .readBurstLen(stdRBurst), .writeBurstLen(), .readStepBytes(stdRStep), .writeStepBytes(),
    .readSeq(), .writeSeq(), .streamStop());

  // Free-running 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  // Only the watchdog ends a wait that never sees an answer.
  task automatic apb(logic [7:0] a, logic [31:0] d, logic wr);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    perr = pslverr;
    rdv = prdata;
    psel <= 0;
    penable <= 0;
  endtask

  // Load all eight data words, launch the given lanes and watch for a push.
  task automatic send(logic [31:0] d [8], logic [31:0] lanes, logic expV);
    for (int i = 0; i < 8; i++) apb(REG_DATA0 + 8'(4 * i), d[i], 1);
    apb(REG_LANES, lanes, 1);
    got = 0;
    gotStd = 0;
    // Sample between edges, where the one-cycle push flags have settled.
    repeat (10) begin
      @(negedge sys_clk);
      if (descValid === 1'b1) got = 1;
      if (stdValid === 1'b1) gotStd = 1;
    end
    @(posedge sys_clk);
    chk("descValid", got, expV);
  endtask

  // Zero means the configured maximum; anything above 128 is capped at 128.
  function automatic logic [10:0] eb(logic [7:0] v);
    return (v == 0) ? MAX_B : (v > 8'h80) ? 11'd128 : {3'b000, v};
  endfunction

  // A writer leaves out the address lanes that the transfer type has no use for.
  function automatic logic [31:0] laneMask(sgdi_xfer_t t);
    return (t == XFER_MM2ST) ? 32'hF0FF_FF0F : (t == XFER_ST2MM) ? 32'hFF0F_FFF0 : 32'hFFFF_FFFF;
  endfunction

  task automatic chkd(logic [31:0] d [8]);
    if (xt != XFER_ST2MM) rs = d[3][15:0];
    if (xt != XFER_MM2ST) ws = d[3][15:0];
    chk("src", descOut.srcAddr, xt == XFER_ST2MM ? 64'h0 : {d[5], d[0]});
    chk("dst", descOut.dstAddr, xt == XFER_MM2ST ? 64'h0 : {d[6], d[1]});
    chk("len", descOut.length, d[2]);
    chk("seq", descOut.seqNum, d[3][15:0]);
    chk("rburst", readBurstLen, eb(d[3][23:16]));
    chk("wburst", writeBurstLen, eb(d[3][31:24]));
    chk("rstep", readStepBytes, d[4][15:0] * DB);
    chk("wstep", writeStepBytes, d[4][31:16] * DB);
    chk("ctrl", descOut.control, d[7]);
    chk("rseq", readSeq, rs);
    chk("wseq", writeSeq, ws);
  endtask

  // Main sequence: bursts, strides and transfer types, then partial lanes.
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    chk("idle", descValid, 0);
    for (int k = 0; k < 9; k++) begin
      for (int i = 0; i < 8; i++) w[i] = $random(seed);
      w[2][0] = 1'b1;
      if (k == 8) w[2] = LENGTH_UNLIMITED;
      w[3][23:16] = bt[k % 5];
      w[3][31:24] = bt[(k + 2) % 5];
      w[4] = {16'(k % 3), 16'((k + 1) % 3)};
      w[7][31] = 1'b1;
      xt <= sgdi_xfer_t'(k % 3);
      send(w, k < 6 ? laneMask(sgdi_xfer_t'(k % 3)) : 32'hFFFF_FFFF, 1);
      chkd(w);
      chk("stdpush", gotStd, w[3][31]);
      if (w[3][31]) begin
        chk("stdsrc", stdDesc.srcAddr, xt == XFER_ST2MM ? 64'h0 : {32'h0, w[0]});
        chk("stdctrl", stdDesc.control, w[3]);
        chk("stdburst", stdRBurst, MAX_B);
        chk("stdstep", stdRStep, DB);
      end
      if (xt == XFER_ST2MM) begin
        streamBytes <= w[2];
        repeat (3) @(posedge sys_clk);
        chk("stop", streamStop, w[2] != LENGTH_UNLIMITED);
        streamEop <= 1;
        repeat (3) @(posedge sys_clk);
        chk("eop", streamStop, 0);
        streamEop <= 0;
        streamBytes <= w[2] - 32'h0000_0001;
        repeat (3) @(posedge sys_clk);
        chk("run", streamStop, 0);
      end
    end
    xt <= XFER_MM2MM;
    for (int i = 0; i < 8; i++) e[i] = $random(seed);
    e[7][31] = 1'b0;
    send(e, 32'hFFFF_FFFF, 0);
    for (int i = 0; i < 8; i++) w[i] = $random(seed);
    w[7][31] = 1'b1;
    send(e, 32'h0FFF_FFFF, 0);
    send(w, 32'hF000_0000, 1);
    e[7] = w[7];
    chkd(e);
    send(w, 32'h0FFF_FFFF, 0);
    chkd(e);
    apb(8'h40, 32'h0000_0000, 1);
    chk("pslverr", perr, 1);
    apb(REG_STATUS, 32'h0000_0000, 0);
    chk("busy", rdv[0], 0);
    apb(REG_COUNT, 32'h0000_0000, 0);
    chk("count", rdv, 32'h0000_000D);
    apb(REG_DATA0 + 8'h1C, 32'h0000_0000, 0);
    chk("word7", rdv, w[7]);
    results();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule
